// ==== core/recorder_params.svh ====
// Register numbers, codes and limits for the pretrigger ring recorder
`ifndef RECORDER_PARAMS_SVH
`define RECORDER_PARAMS_SVH

// ==========================================
// Register numbers
`define REG_COMMAND_WORD 18'h00000
`define REG_RECORDER_STATE 18'h0000A
`define REG_CAPTURE_DEPTH 18'h02710
`define REG_AFTER_TRIGGER 18'h02774
`define REG_TERM_CH0 18'h0754E
`define REG_TERM_CH1 18'h075B2
`define REG_TERM_CH2 18'h07616
`define REG_TERM_CH3 18'h0767A
`define REG_CALIB_LOAD 18'h0C350
`define REG_CALIB_STORE 18'h0C35A
`define REG_AUTO_ADJUST 18'h0C364
`define REG_OVR_TAG_EN 18'h31128

// ==========================================
// Codes
`define CMD_LAUNCH 32'h0000000A
`define CMD_HALT 32'h00000014
`define STATE_AWAITING 32'h00000000
`define STATE_TRIGGERED 32'h0000000A
`define STATE_FINISHED 32'h00000014
`define FACTORY_CALIB_SET 32'h00000000
`define USER_CALIB_SET_FIRST 32'h00000001

// ==========================================
// Sample word layout and limits
`define OVR_BIT 15
`define SMP_MSB 11
`define ADDR_W 28
`define MAX_POST_ONE 32'h08000000
`define MAX_POST_TWO 32'h04000000
`define MAX_POST_FOUR 32'h02000000
`define ZERO32 32'h00000000
`define ONE32 32'h00000001

`endif

// ==== core/recorder_pkg.sv ====
// Types shared by the pretrigger ring recorder
package recorder_pkg;
   `include "recorder_params.svh"

   typedef enum logic [1:0] {ST_FINISHED, ST_FILL, ST_ARMED, ST_TRIGGERED} rec_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [17:0] addr;
      logic [31:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      logic [11:0] data;
      logic overrange;
   } sample_s;

   typedef struct packed {
      logic we;
      logic [27:0] addr;
      logic [15:0] wdata;
   } mem_wr_s;

   typedef struct packed {
      logic load;
      logic store;
      logic adjust;
      logic [31:0] code;
   } calib_req_s;
endpackage

// ==== core/pretrigger_ring_recorder.sv ====
// Ring-buffer acquisition control with post-trigger count and calibration requests
`include "recorder_params.svh"

// Summary of operation
// - With over-range tagging on, converter over-range flag goes to sample bit 15.
// - Stored flag is 1 for an out-of-range sample, 0 when within range.
// - Flag is taken per sample, never held or accumulated.
// - Read/write enable register; nonzero turns on over-range tagging.
// - Per-channel termination: 1 selects 50 ohm, 0 selects 1 megaohm.
// - Writing auto adjust register starts offset compensation; 0 means all ranges.
// - Writing load register restores a set; reading returns last loaded set.
// - Factory set is loaded automatically after reset, before any host request.
// - Writing store register saves current values; reading returns last stored set, or set 1 if none is stored since reset.
// - Set 0 is factory, load only; set 1 is first user set, storable.
// - Once started, samples are taken on each equidistant strobe and kept.
// - Programmed region is written as a ring until a trigger arrives.
// - After trigger, exactly the post-trigger count is recorded, then stop.
// - Pretrigger depth equals memory size minus post-trigger count.
// - Trigger stays disarmed until the pretrigger portion is filled.
// - Read/write memory size sets total depth in samples per channel.
// - Read/write post-trigger register sets samples taken after trigger.
// - Post-trigger count is limited by a maximum set by active channels.
// - Data stays in memory after the end for host readout.
// - Command 10 starts acquisition, command 20 stops it at once.
// - Status reads 0 awaiting trigger, 10 triggered, 20 stopped.
module pretrigger_ring_recorder
(
   input wire logic clk,
   input wire logic srst,
   input wire recorder_pkg::reg_req_s reg_req,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire recorder_pkg::sample_s smp,
   input wire logic trigger_in,
   input wire logic [2:0] active_channels,
   output recorder_pkg::mem_wr_s mem_wr,
   output logic [27:0] ring_start_addr,
   output logic [3:0] termination_50ohm,
   output recorder_pkg::calib_req_s calib_req
);
   import recorder_pkg::*;

   // ==========================================
   // State record
   typedef struct packed {
      rec_state_e st;
      logic [31:0] depth;
      logic [31:0] post;
      logic [31:0] post_eff;
      logic [31:0] pre;
      logic [31:0] cnt;
      logic [3:0] term;
      logic ovr_en;
      logic [31:0] last_load;
      logic [31:0] last_store;
      logic [31:0] cmd;
      logic boot;
      logic [27:0] wr_addr;
      logic [27:0] ring_start;
      mem_wr_s mem;
      calib_req_s cal;
      logic [31:0] rdata;
      logic rvalid;
   } core_s;

   core_s q;
   core_s d;
   logic [27:0] addr_inc;
   logic [27:0] addr_next;
   logic [31:0] post_max;
   logic [31:0] post_lim;
   logic [31:0] cnt_inc;
   logic writing;

   // ==========================================
   // Helpers
   always_comb
   begin
      addr_inc = q.wr_addr + 28'h0000001;
      addr_next = (addr_inc >= q.depth[27:0]) ? 28'h0000000 : addr_inc;
      unique case (active_channels)
         3'h1: post_max = `MAX_POST_ONE;
         3'h2: post_max = `MAX_POST_TWO;
         default: post_max = `MAX_POST_FOUR;
      endcase
      post_lim = (q.post > post_max) ? post_max : q.post;
      cnt_inc = q.cnt + `ONE32;
      writing = smp.valid && (q.st != ST_FINISHED);
   end

   // ==========================================
   // Next state
   always_comb
   begin
      d = q;
      d.mem.we = 1'b0;
      d.cal.load = 1'b0;
      d.cal.store = 1'b0;
      d.cal.adjust = 1'b0;
      d.rvalid = 1'b0;

      // Factory set first, ahead of any host request
      if (q.boot)
      begin
         d.boot = 1'b0;
         d.cal.load = 1'b1;
         d.cal.code = `FACTORY_CALIB_SET;
         d.last_load = `FACTORY_CALIB_SET;
      end

      // Sample path: tag or sign-extend, per sample
      if (writing)
      begin
         d.mem.we = 1'b1;
         d.mem.addr = q.wr_addr;
         d.mem.wdata = {{4{smp.data[`SMP_MSB]}}, smp.data};
         if (q.ovr_en)
         begin
            d.mem.wdata[`OVR_BIT] = smp.overrange;
         end
         d.wr_addr = addr_next;
      end

      // Recorder sequence
      unique case (q.st)
         ST_FILL:
         begin
            if (writing)
            begin
               d.cnt = cnt_inc;
               if (cnt_inc >= q.pre)
               begin
                  d.st = ST_ARMED;
               end
            end
         end
         ST_ARMED:
         begin
            if (trigger_in)
            begin
               d.cnt = `ZERO32;
               d.st = ST_TRIGGERED;
               if (q.post_eff == `ZERO32)
               begin
                  d.st = ST_FINISHED;
                  d.ring_start = writing ? addr_next : q.wr_addr;
               end
            end
         end
         ST_TRIGGERED:
         begin
            if (writing)
            begin
               d.cnt = cnt_inc;
               if (cnt_inc >= q.post_eff)
               begin
                  d.st = ST_FINISHED;
                  d.ring_start = addr_next;
               end
            end
         end
         ST_FINISHED:
         begin
         end
      endcase

      // Register writes
      if (q.boot == 1'b0 && reg_req.wr)
      begin
         unique case (reg_req.addr)
            `REG_COMMAND_WORD:
            begin
               d.cmd = reg_req.wdata;
               if (reg_req.wdata == `CMD_LAUNCH)
               begin
                  d.post_eff = post_lim;
                  d.pre = (q.depth > post_lim) ? q.depth - post_lim : `ZERO32;
                  d.cnt = `ZERO32;
                  d.wr_addr = 28'h0000000;
                  d.st = (q.depth > post_lim) ? ST_FILL : ST_ARMED;
               end
               else if (reg_req.wdata == `CMD_HALT)
               begin
                  d.st = ST_FINISHED;
                  d.ring_start = d.wr_addr;
               end
            end
            `REG_CAPTURE_DEPTH: d.depth = reg_req.wdata;
            `REG_AFTER_TRIGGER: d.post = reg_req.wdata;
            `REG_TERM_CH0: d.term[0] = (reg_req.wdata != `ZERO32);
            `REG_TERM_CH1: d.term[1] = (reg_req.wdata != `ZERO32);
            `REG_TERM_CH2: d.term[2] = (reg_req.wdata != `ZERO32);
            `REG_TERM_CH3: d.term[3] = (reg_req.wdata != `ZERO32);
            `REG_OVR_TAG_EN: d.ovr_en = (reg_req.wdata != `ZERO32);
            `REG_CALIB_LOAD:
            begin
               d.cal.load = 1'b1;
               d.cal.code = reg_req.wdata;
               d.last_load = reg_req.wdata;
            end
            `REG_CALIB_STORE:
            begin
               // Factory set is protected; the request is dropped silently
               if (reg_req.wdata != `FACTORY_CALIB_SET)
               begin
                  d.cal.store = 1'b1;
                  d.cal.code = reg_req.wdata;
                  d.last_store = reg_req.wdata;
               end
            end
            `REG_AUTO_ADJUST:
            begin
               d.cal.adjust = 1'b1;
               d.cal.code = reg_req.wdata;
            end
            default:
            begin
            end
         endcase
      end

      // Register reads, answered next cycle
      if (reg_req.rd)
      begin
         d.rvalid = 1'b1;
         unique case (reg_req.addr)
            `REG_COMMAND_WORD: d.rdata = q.cmd;
            `REG_RECORDER_STATE:
            begin
               unique case (q.st)
                  ST_TRIGGERED: d.rdata = `STATE_TRIGGERED;
                  ST_FINISHED: d.rdata = `STATE_FINISHED;
                  default: d.rdata = `STATE_AWAITING;
               endcase
            end
            `REG_CAPTURE_DEPTH: d.rdata = q.depth;
            `REG_AFTER_TRIGGER: d.rdata = q.post;
            `REG_TERM_CH0: d.rdata = {31'h00000000, q.term[0]};
            `REG_TERM_CH1: d.rdata = {31'h00000000, q.term[1]};
            `REG_TERM_CH2: d.rdata = {31'h00000000, q.term[2]};
            `REG_TERM_CH3: d.rdata = {31'h00000000, q.term[3]};
            `REG_OVR_TAG_EN: d.rdata = {31'h00000000, q.ovr_en};
            `REG_CALIB_LOAD: d.rdata = q.last_load;
            `REG_CALIB_STORE: d.rdata = q.last_store;
            default: d.rdata = `ZERO32;
         endcase
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '0;
         q.st <= ST_FINISHED;
         q.boot <= 1'b1;
         q.last_store <= `USER_CALIB_SET_FIRST;
      end
      else
      begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign mem_wr = q.mem;
   assign ring_start_addr = q.ring_start;
   assign termination_50ohm = q.term;
   assign calib_req = q.cal;

   // ==========================================
   // Checks
   ovr_tag_set_a: assert property (@(posedge clk) disable iff (srst)
      (writing && q.ovr_en) |=> (mem_wr.we && mem_wr.wdata[15] == $past(smp.overrange)))
      else $error("over-range flag not stored in bit 15");

   plain_sample_a: assert property (@(posedge clk) disable iff (srst)
      (writing && !q.ovr_en) |=>
      (mem_wr.wdata == {{4{$past(smp.data[11])}}, $past(smp.data)}))
      else $error("untagged sample word wrong");

   term_write_a: assert property (@(posedge clk) disable iff (srst)
      (reg_req.wr && !q.boot && reg_req.addr == `REG_TERM_CH2) |=>
      (termination_50ohm[2] == ($past(reg_req.wdata) != 32'h00000000)))
      else $error("termination select not taken");

   boot_load_a: assert property (@(posedge clk)
      ($past(srst) && !srst) |=> (calib_req.load && calib_req.code == 32'h00000000))
      else $error("factory set not loaded after reset");

   factory_guard_a: assert property (@(posedge clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == `REG_CALIB_STORE && reg_req.wdata == 32'h00000000)
      |=> !calib_req.store)
      else $error("store to factory set issued");

   halt_now_a: assert property (@(posedge clk) disable iff (srst)
      (reg_req.wr && !q.boot && reg_req.addr == `REG_COMMAND_WORD
      && reg_req.wdata == 32'h00000014) |=> (q.st == ST_FINISHED))
      else $error("halt did not stop recorder");

   ring_wrap_a: assert property (@(posedge clk) disable iff (srst)
      (mem_wr.we && q.depth != 32'h00000000 && $stable(q.depth)) |-> mem_wr.addr < q.depth[27:0])
      else $error("write address beyond ring");

   disarmed_fill_a: assert property (@(posedge clk) disable iff (srst)
      (q.st == ST_FILL && trigger_in && !reg_req.wr) |=> (q.st != ST_TRIGGERED))
      else $error("trigger accepted during pretrigger fill");

   post_exact_a: assert property (@(posedge clk) disable iff (srst)
      (q.st == ST_TRIGGERED && $past(q.st) == ST_TRIGGERED && !$past(reg_req.wr))
      |-> (q.cnt < q.post_eff))
      else $error("post-trigger count overran");
endmodule

// ==== test/host_bus_model.sv ====
// Host-side model: register access to the recorder and a capture of on-board memory
`include "recorder_params.svh"
module host_bus_model
(
   input wire logic clk,
   output recorder_pkg::reg_req_s reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire recorder_pkg::mem_wr_s mem_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   import recorder_pkg::*;
   logic [15:0] mem [0:31];
   int writes = 0;
   initial reg_req = '0;
   // ==========================================
   // Memory capture, kept after the run for readout
   always @(posedge clk)
   begin
      if (mem_wr.we === 1'b1)
      begin
         mem[mem_wr.addr[4:0]] <= mem_wr.wdata;
         writes <= writes + 1;
      end
   end
   // ==========================================
   // Requests start one edge after entry, so back-to-back calls never collide
   task automatic put(input logic [17:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      reg_req = {1'b1, 1'b0, a, d};
      @(posedge clk);
      #1;
      reg_req = {1'b0, 1'b0, ~a, ~d}; // Released lines do not keep the old value
   endtask
   task automatic get(input logic [17:0] a, output logic [31:0] d, output bit ok);
      ok = 0;
      d = 32'h0;
      @(posedge clk);
      #1;
      reg_req = {1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      #1;
      reg_req = {1'b0, 1'b0, ~a, 32'hFFFFFFFF};
      for (int n = 0; n < 4 && !ok; n++)
      begin
         if (reg_rvalid === 1'b1)
         begin
            ok = 1;
            d = reg_rdata;
         end
         else
         begin
            @(posedge clk);
            #1;
         end
      end
   endtask
endmodule

// ==== test/pretrigger_ring_recorder_tb_top.sv ====
// Self-checking bench for the pretrigger ring recorder
`include "recorder_params.svh"
module pretrigger_ring_recorder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import recorder_pkg::*;
   logic clk, srst, trigger_in;
   logic [2:0] active_channels;
   sample_s smp;
   reg_req_s reg_req;
   logic [31:0] reg_rdata, v, last_code;
   logic reg_rvalid;
   mem_wr_s mem_wr;
   logic [27:0] ring_start_addr;
   logic [3:0] termination_50ohm;
   calib_req_s calib_req;
   int miscompares, checks, loads, stores, adjusts;
   bit ok;
   logic [17:0] term_addr [4] = '{`REG_TERM_CH0, `REG_TERM_CH1, `REG_TERM_CH2, `REG_TERM_CH3};
   logic [3:0] pats [2] = '{4'hD, 4'h2};
   pretrigger_ring_recorder u_dut (.clk(clk), .srst(srst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .smp(smp), .trigger_in(trigger_in),
      .active_channels(active_channels), .mem_wr(mem_wr), .ring_start_addr(ring_start_addr),
      .termination_50ohm(termination_50ohm), .calib_req(calib_req));
   host_bus_model u_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .mem_wr(mem_wr));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================
   // Calibration pulse monitor
   always @(posedge clk)
   begin
      if (srst)
      begin
         loads <= 0;
         stores <= 0;
         adjusts <= 0;
      end
      else
      begin
         loads <= loads + (calib_req.load === 1'b1);
         stores <= stores + (calib_req.store === 1'b1);
         adjusts <= adjusts + (calib_req.adjust === 1'b1);
         if (calib_req.load || calib_req.store || calib_req.adjust)
            last_code <= calib_req.code;
      end
   end
   // ==========================================
   // Tasks
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input string what, input logic [17:0] a, input logic [31:0] exp);
      u_host.get(a, v, ok);
      if (!ok)
      begin
         miscompares++;
         $display("MISMATCH %s expected answer seen none", what);
         wrap_up();
      end
      else
         chk(what, exp, v);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic [11:0] d, input logic o);
      @(posedge clk);
      #1;
      smp = {1'b1, d, o};
      @(posedge clk);
      #1;
      smp = {1'b0, ~d, ~o};
   endtask
   task automatic fire();
      @(posedge clk);
      #1;
      trigger_in = 1'b1;
      @(posedge clk);
      #1;
      trigger_in = 1'b0;
   endtask
   task automatic launch(input logic [31:0] depth, post, tag, input logic [2:0] ch);
      active_channels = ch;
      u_host.put(`REG_CAPTURE_DEPTH, depth);
      u_host.put(`REG_AFTER_TRIGGER, post);
      u_host.put(`REG_OVR_TAG_EN, tag);
      rd_chk("depth", `REG_CAPTURE_DEPTH, depth);
      rd_chk("post count", `REG_AFTER_TRIGGER, post);
      rd_chk("tag enable", `REG_OVR_TAG_EN, tag);
      u_host.put(`REG_COMMAND_WORD, `CMD_LAUNCH);
   endtask
   function automatic logic [11:0] dat(input int k);
      return 12'(k * 165 + 1900);
   endfunction
   // ==========================================
   // Main sequence
   initial
   begin
      srst = 1'b1;
      trigger_in = 1'b0;
      active_channels = 3'h2;
      smp = '0;
      miscompares = 0;
      checks = 0;
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("start-up loads", 32'h1, loads);
      chk("start-up set", `FACTORY_CALIB_SET, last_code);
      rd_chk("status", `REG_RECORDER_STATE, `STATE_FINISHED);
      rd_chk("load set", `REG_CALIB_LOAD, `FACTORY_CALIB_SET);
      u_host.put(`REG_CALIB_LOAD, `USER_CALIB_SET_FIRST);
      u_host.put(`REG_CALIB_STORE, `FACTORY_CALIB_SET);
      u_host.put(`REG_AUTO_ADJUST, 32'h0);
      settle();
      chk("loads", 32'h2, loads);
      chk("stores", 32'h0, stores);
      chk("adjusts", 32'h1, adjusts);
      chk("adjust mode", 32'h0, last_code);
      rd_chk("load set", `REG_CALIB_LOAD, `USER_CALIB_SET_FIRST);
      rd_chk("store set", `REG_CALIB_STORE, `USER_CALIB_SET_FIRST);
      u_host.put(`REG_CALIB_STORE, `USER_CALIB_SET_FIRST);
      settle();
      chk("stores", 32'h1, stores);
      chk("store set code", `USER_CALIB_SET_FIRST, last_code);
      rd_chk("adjust reads", `REG_AUTO_ADJUST, 32'h0);
      rd_chk("unmapped", 18'h00005, 32'h0);
      foreach (pats[p])
      begin
         for (int c = 0; c < 4; c++)
            u_host.put(term_addr[c], {31'h0, pats[p][c]});
         settle();
         chk("termination pins", {28'h0, pats[p]}, {28'h0, termination_50ohm});
         for (int c = 0; c < 4; c++)
            rd_chk("termination", term_addr[c], {31'h0, pats[p][c]});
      end
      // Two channels: step 16, pretrigger 16, trigger during fill must be ignored
      launch(32'h20, 32'h10, 32'h1, 3'h2);
      rd_chk("status", `REG_RECORDER_STATE, `STATE_AWAITING);
      for (int k = 0; k < 40; k++)
      begin
         if (k == 8)
            fire();
         if (k == 24)
         begin
            fire();
            rd_chk("status", `REG_RECORDER_STATE, `STATE_TRIGGERED);
         end
         send(dat(k), k[1]);
      end
      settle();
      rd_chk("status", `REG_RECORDER_STATE, `STATE_FINISHED);
      chk("writes", 32'h28, u_host.writes);
      chk("ring start", 32'h8, {4'h0, ring_start_addr});
      send(12'h123, 1'b1);
      settle();
      chk("writes after end", 32'h28, u_host.writes);
      for (int a = 0; a < 32; a++)
      begin
         v[11:0] = dat(a < 8 ? a + 32 : a);
         chk("tagged word", {16'h0, a[1], {3{v[11]}}, v[11:0]}, {16'h0, u_host.mem[a]});
      end
      // Four channels, tagging off, post equal to depth: armed at once
      launch(32'h10, 32'h10, 32'h0, 3'h4);
      fire();
      rd_chk("status", `REG_RECORDER_STATE, `STATE_TRIGGERED);
      for (int k = 0; k < 16; k++)
         send(12'h800 | 12'(k), 1'b1);
      settle();
      rd_chk("status", `REG_RECORDER_STATE, `STATE_FINISHED);
      chk("writes", 32'h38, u_host.writes);
      chk("ring start", 32'h0, {4'h0, ring_start_addr});
      for (int a = 0; a < 16; a++)
         chk("plain word", {16'h0, 4'hF, 12'h800 | 12'(a)}, {16'h0, u_host.mem[a]});
      // Halt during fill, before any sample is sent; one channel needs sizes in steps of 32
      launch(32'h40, 32'h20, 32'h1, 3'h1);
      u_host.put(`REG_COMMAND_WORD, `CMD_HALT);
      rd_chk("status", `REG_RECORDER_STATE, `STATE_FINISHED);
      rd_chk("command", `REG_COMMAND_WORD, `CMD_HALT);
      send(12'h055, 1'b0);
      settle();
      chk("writes after halt", 32'h38, u_host.writes);
      wrap_up();
   end
endmodule
